// ---- ssl_cis_mem.sv ----
`timescale 1ns/1ps
module ssl_cis_mem (
  input wire logic sys_clk,
  input wire logic [3:0] wr_be,
  input wire logic [4:0] wr_addr,
  input wire logic [31:0] wr_data,
  input wire logic [4:0] rd_addr,
  output logic [31:0] rd_data
);
  // one array per byte lane, so each has a single writer
  genvar lane;
  generate
    for (lane = 0; lane < 4; lane++) begin : g_lane
      logic [7:0] lane_mem [0:31];
      logic [7:0] lane_q;
      always_ff @(posedge sys_clk) begin
        if (wr_be[lane]) begin
          lane_mem[wr_addr] <= wr_data[lane*8 +: 8];
        end
        lane_q <= lane_mem[rd_addr];
      end
      assign rd_data[lane*8 +: 8] = lane_q;
    end
  endgenerate
endmodule

// ---- ssl_consts.svh ----
`ifndef SSL_CONSTS_SVH
`define SSL_CONSTS_SVH

// ----------------------------------------
// register byte addresses
// ----------------------------------------
`define SSL_A_SUBSYS     12'h930
`define SSL_A_LATENCY_VALUES_STAGE     12'h934
`define SSL_A_GUID_HI    12'h938
`define SSL_A_GUID_LO    12'h93C
`define SSL_A_PAGE_WR    12'h940
`define SSL_A_STATUS     12'h944
`define SSL_A_LAT        12'h950
`define SSL_A_GEN0       12'h954
`define SSL_A_GEN1       12'h958
`define SSL_A_GEN2       12'h95C
`define SSL_A_PHYS       12'h960
`define SSL_A_CIS_EVEN   12'h980
`define SSL_A_CIS_ODD    12'h984

// ----------------------------------------
// fields and reset values
// ----------------------------------------
`define SSL_PW_TRIG_BIT  0
`define SSL_PW_PAGE_LSB  4
`define SSL_LAT_MSB      7
`define SSL_LAT_LSB      3
`define SSL_PHY_PROG_BIT 9
`define SSL_PHY_ENH_BIT  8
`define SSL_PHY_PROG_RST 1'b1
`define SSL_PHY_ENH_RST  1'b0
`define SSL_PHY_LOW_ONES 3'h7

// ----------------------------------------
// page codes
// ----------------------------------------
`define SSL_PG_IDS       3'h0
`define SSL_PG_GUID      3'h1
`define SSL_PG_LATGEN    3'h2
`define SSL_PG_GEN12     3'h3
`define SSL_PG_PHY       3'h4
`define SSL_PG_CIS       3'h5

// ----------------------------------------
// eeprom image layout
// ----------------------------------------
`define SSL_EE_CONST6    8'h08
`define SSL_EE_CONST23   8'h07
`define SSL_EE_MAXLAT    8'h04
`define SSL_EE_MINGNT    8'h05
`define SSL_EE_MAXREC    8'h07
`define SSL_EE_LAT       8'h13
`define SSL_EE_GEN0      8'h14
`define SSL_EE_GEN_END   8'h1F
`define SSL_EE_PHY       8'h22
`define SSL_EE_CIS0      8'h28
`define SSL_EE_CIS_END   8'hA7
`define SSL_EE_BASE_END  8'h23
`define SSL_PAGE_LAST    3'h7

// ----------------------------------------
// axi responses
// ----------------------------------------
`define SSL_RESP_OKAY    2'h0
`define SSL_RESP_SLVERR  2'h2

`endif

// ---- ssl_ee_model.sv ----
`timescale 1ns/1ps
module ssl_ee_model import ssl_pkg::*; (
  input wire logic sys_clk,
  input wire logic slow,
  input wire ssl_ee_req_t ee_req,
  output logic ee_ack,
  output logic [7:0] ee_rdata
);
  logic [7:0] mem [0:255];
  logic [2:0] wait_cnt;
  initial begin
    for (int i = 0; i < 256; i++) mem[i] = 8'(i + 8'h40);
    mem[8'h22] = 8'h01;
    ee_ack = 1'b0;
    ee_rdata = 8'h00;
    wait_cnt = 3'h0;
  end
  always @(posedge sys_clk) begin
    if (ee_req.req && !ee_ack && wait_cnt >= (slow ? 3'h3 : 3'h0)) begin
      ee_ack <= 1'b1;
      wait_cnt <= 3'h0;
      if (ee_req.write) mem[ee_req.addr] <= ee_req.wdata;
      ee_rdata <= ee_req.write ? ~ee_rdata : mem[ee_req.addr];
    end else begin
      ee_ack <= 1'b0;
      ee_rdata <= ~ee_rdata;
      if (ee_req.req && !ee_ack) wait_cnt <= wait_cnt + 3'h1;
    end
  end
endmodule

// ---- ssl_param_loader.sv ----
// Chosen here: register access over AXI4-Lite.
`timescale 1ns/1ps
`include "ssl_consts.svh"
module ssl_param_loader import ssl_pkg::*; (
  input wire logic sys_clk,
  input wire logic arst_n,
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic loader_enable_strap,
  input wire logic card_mode_strap,
  input wire logic card_info_enable_strap,
  output ssl_ee_req_t ee_req,
  input wire logic ee_ack,
  input wire logic [7:0] ee_rdata,
  output ssl_cfg_t cfg,
  input wire logic [4:0] cis_rd_addr,
  output logic [31:0] cis_rd_data,
  output logic busy
);
  // ----------------------------------------
  // staging registers
  // ----------------------------------------
  logic [31:0] subsystem_ids_stage;
  logic [31:0] latency_values_stage;
  logic [31:0] unique_id_high_stage;
  logic [31:0] unique_id_low_stage;
  logic [4:0] latency_timer_stage;
  logic [2:0][31:0] general_stage;
  logic phy_program_enable_stage;
  logic phy_enhance_enable_stage;
  logic [31:0] card_info_stage_even;
  logic [31:0] card_info_stage_odd;
  logic [2:0] page_sel;
  logic [3:0] cis_pair;
  logic load_pending;
  logic load_done;
  logic card_mode;

  // ----------------------------------------
  // axi write side
  // ----------------------------------------
  logic [11:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  wire wr_fire = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;
  wire wr_ok = (aw_addr >= `SSL_A_SUBSYS && aw_addr <= `SSL_A_STATUS)
    || (aw_addr >= `SSL_A_LAT && aw_addr <= `SSL_A_PHYS)
    || aw_addr == `SSL_A_CIS_EVEN || aw_addr == `SSL_A_CIS_ODD;
  wire wr_ok_aligned = wr_ok && aw_addr[1:0] == 2'h0;

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] strb);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return res;
  endfunction

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `SSL_RESP_OKAY;
      aw_addr <= 12'h000;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        s_axi_awready <= 1'b0;
        aw_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        s_axi_wready <= 1'b0;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (wr_fire) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_ok_aligned ? `SSL_RESP_OKAY : `SSL_RESP_SLVERR;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  // ----------------------------------------
  // register writes
  // ----------------------------------------
  wire sel_w = wr_fire && wr_ok_aligned;
  wire trig_write = sel_w && aw_addr == `SSL_A_PAGE_WR && w_strb[0]
    && w_data[`SSL_PW_TRIG_BIT];
  wire [2:0] trig_page = w_data[`SSL_PW_PAGE_LSB +: 3];
  wire trig_go = trig_write && !busy && trig_page <= `SSL_PG_CIS;

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      subsystem_ids_stage <= 32'h0000_0000;
      latency_values_stage <= 32'h0000_0000;
      unique_id_high_stage <= 32'h0000_0000;
      unique_id_low_stage <= 32'h0000_0000;
      latency_timer_stage <= 5'h00;
      general_stage <= '0;
      phy_program_enable_stage <= `SSL_PHY_PROG_RST;
      phy_enhance_enable_stage <= `SSL_PHY_ENH_RST;
      card_info_stage_even <= 32'h0000_0000;
      card_info_stage_odd <= 32'h0000_0000;
    end else if (sel_w) begin
      case (aw_addr)
        `SSL_A_SUBSYS: subsystem_ids_stage <= merge(subsystem_ids_stage, w_data, w_strb);
        `SSL_A_LATENCY_VALUES_STAGE: latency_values_stage <= merge(latency_values_stage, w_data, w_strb);
        `SSL_A_GUID_HI: unique_id_high_stage <= merge(unique_id_high_stage, w_data, w_strb);
        `SSL_A_GUID_LO: unique_id_low_stage <= merge(unique_id_low_stage, w_data, w_strb);
        `SSL_A_LAT: begin
          if (w_strb[0]) begin
            latency_timer_stage <= w_data[`SSL_LAT_MSB:`SSL_LAT_LSB];
          end
        end
        `SSL_A_GEN0: general_stage[0] <= merge(general_stage[0], w_data, w_strb);
        `SSL_A_GEN1: general_stage[1] <= merge(general_stage[1], w_data, w_strb);
        `SSL_A_GEN2: general_stage[2] <= merge(general_stage[2], w_data, w_strb);
        `SSL_A_PHYS: begin
          if (w_strb[1]) begin
            phy_program_enable_stage <= w_data[`SSL_PHY_PROG_BIT];
            phy_enhance_enable_stage <= w_data[`SSL_PHY_ENH_BIT];
          end
        end
        `SSL_A_CIS_EVEN: card_info_stage_even <= merge(card_info_stage_even, w_data, w_strb);
        `SSL_A_CIS_ODD: card_info_stage_odd <= merge(card_info_stage_odd, w_data, w_strb);
        default: ;
      endcase
    end
  end

  // ----------------------------------------
  // axi read side
  // ----------------------------------------
  wire [31:0] status_word = {23'h0, cis_pair, 3'h0, load_done, busy};
  wire [31:0] rd_mux =
    (s_axi_araddr == `SSL_A_SUBSYS) ? subsystem_ids_stage :
    (s_axi_araddr == `SSL_A_LATENCY_VALUES_STAGE) ? latency_values_stage :
    (s_axi_araddr == `SSL_A_GUID_HI) ? unique_id_high_stage :
    (s_axi_araddr == `SSL_A_GUID_LO) ? unique_id_low_stage :
    (s_axi_araddr == `SSL_A_STATUS) ? status_word :
    (s_axi_araddr == `SSL_A_LAT) ? {24'h0, latency_timer_stage, 3'h0} :
    (s_axi_araddr == `SSL_A_GEN0) ? general_stage[0] :
    (s_axi_araddr == `SSL_A_GEN1) ? general_stage[1] :
    (s_axi_araddr == `SSL_A_GEN2) ? general_stage[2] :
    (s_axi_araddr == `SSL_A_PHYS) ? {22'h0, phy_program_enable_stage,
                                     phy_enhance_enable_stage, 5'h00, `SSL_PHY_LOW_ONES} :
    (s_axi_araddr == `SSL_A_CIS_EVEN) ? card_info_stage_even :
    (s_axi_araddr == `SSL_A_CIS_ODD) ? card_info_stage_odd : 32'h0000_0000;
  wire rd_ok = ((s_axi_araddr >= `SSL_A_SUBSYS && s_axi_araddr <= `SSL_A_STATUS)
    || (s_axi_araddr >= `SSL_A_LAT && s_axi_araddr <= `SSL_A_PHYS)
    || s_axi_araddr == `SSL_A_CIS_EVEN || s_axi_araddr == `SSL_A_CIS_ODD)
    && s_axi_araddr[1:0] == 2'h0;

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= `SSL_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_mux;
      s_axi_rresp <= rd_ok ? `SSL_RESP_OKAY : `SSL_RESP_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  // ----------------------------------------
  // page image for eeprom writes
  // ----------------------------------------
  // msb-first image bytes
  wire [63:0] page_data =
    (page_sel == `SSL_PG_IDS) ? {subsystem_ids_stage, latency_values_stage[31:16],
                                 `SSL_EE_CONST6, 4'h0, latency_values_stage[3:0]} :
    (page_sel == `SSL_PG_GUID) ? {unique_id_high_stage, unique_id_low_stage} :
    (page_sel == `SSL_PG_LATGEN) ? {24'h0, latency_timer_stage, 3'h0, general_stage[0]} :
    (page_sel == `SSL_PG_GEN12) ? {general_stage[1], general_stage[2]} :
    (page_sel == `SSL_PG_PHY) ? {16'h0, 6'h00, phy_program_enable_stage,
                                 phy_enhance_enable_stage, `SSL_EE_CONST23, 32'h0} :
    {card_info_stage_even, card_info_stage_odd};
  // card pair address steps by eight
  wire [7:0] page_base = (page_sel == `SSL_PG_CIS) ? `SSL_EE_CIS0 + {1'b0, cis_pair, 3'h0}
                                                   : {2'h0, page_sel, 3'h0};

  // ----------------------------------------
  // transfer sequencer
  // ----------------------------------------
  ssl_state_t state;
  logic op_load;
  logic [7:0] cur_addr;
  logic [7:0] last_addr;
  logic [2:0] byte_idx;
  wire last_byte = op_load ? (cur_addr == last_addr) : (byte_idx == `SSL_PAGE_LAST);
  wire byte_done = state == SSL_WAIT && ee_ack;
  wire load_go = load_pending && loader_enable_strap;
  // card words only in card mode or with enable low
  wire load_cis = card_mode_strap || !card_info_enable_strap;

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      state <= SSL_IDLE;
      op_load <= 1'b0;
      cur_addr <= 8'h00;
      last_addr <= 8'h00;
      byte_idx <= 3'h0;
      page_sel <= `SSL_PG_IDS;
      cis_pair <= 4'h0;
      load_pending <= 1'b1;
      load_done <= 1'b0;
      card_mode <= 1'b0;
      busy <= 1'b1;
      ee_req <= '0;
    end else begin
      // straps caught once, right after reset
      load_pending <= 1'b0;
      if (load_pending) begin
        card_mode <= card_mode_strap;
      end
      case (state)
        SSL_IDLE: begin
          busy <= load_go || trig_go;
          if (load_go) begin
            op_load <= 1'b1;
            cur_addr <= 8'h00;
            last_addr <= load_cis ? `SSL_EE_CIS_END : `SSL_EE_BASE_END;
            state <= SSL_REQ;
          end else if (trig_go) begin
            op_load <= 1'b0;
            page_sel <= trig_page;
            byte_idx <= 3'h0;
            state <= SSL_REQ;
          end
        end
        SSL_REQ: begin
          ee_req.req <= 1'b1;
          ee_req.write <= !op_load;
          ee_req.addr <= op_load ? cur_addr : page_base + {5'h00, byte_idx};
          ee_req.wdata <= op_load ? 8'h00 : page_data[{~byte_idx, 3'h0} +: 8];
          state <= SSL_WAIT;
        end
        SSL_WAIT: begin
          if (ee_ack) begin
            ee_req.req <= 1'b0;
            cur_addr <= cur_addr + 8'h01;
            byte_idx <= byte_idx + 3'h1;
            if (last_byte) begin
              state <= SSL_IDLE;
              busy <= 1'b0;
              load_done <= load_done || op_load;
              if (!op_load && page_sel == `SSL_PG_CIS) begin
                cis_pair <= cis_pair + 4'h1;
              end
            end else begin
              state <= SSL_REQ;
            end
          end
        end
        default: begin
          state <= SSL_IDLE;
          busy <= 1'b0;
        end
      endcase
    end
  end

  // ----------------------------------------
  // placing loaded bytes
  // ----------------------------------------
  wire ld_stb = byte_done && op_load;
  wire [4:0] ld_shift = {2'h3 - cur_addr[1:0], 3'h0};
  wire [7:0] gen_off = cur_addr - `SSL_EE_GEN0;
  wire [7:0] cis_off = cur_addr - `SSL_EE_CIS0;
  wire in_ids = cur_addr < `SSL_EE_MAXLAT;
  wire in_guid_hi = cur_addr[7:2] == 6'h02;
  wire in_guid_lo = cur_addr[7:2] == 6'h03;
  wire in_gen = cur_addr >= `SSL_EE_GEN0 && cur_addr <= `SSL_EE_GEN_END;
  wire in_cis = cur_addr >= `SSL_EE_CIS0 && cur_addr <= `SSL_EE_CIS_END;
  wire [3:0] cis_be = (ld_stb && in_cis) ? 4'h1 << (2'h3 - cur_addr[1:0]) : 4'h0;

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      cfg <= '0;
      cfg.phy_program_bit <= `SSL_PHY_PROG_RST;
    end else if (ld_stb) begin
      if (in_ids) begin
        cfg.subsys_ids[ld_shift +: 8] <= ee_rdata;
      end
      if (in_guid_hi) begin
        cfg.guid_hi[ld_shift +: 8] <= ee_rdata;
      end
      if (in_guid_lo) begin
        cfg.guid_lo[ld_shift +: 8] <= ee_rdata;
      end
      if (in_gen) begin
        cfg.general[gen_off[3:2]][ld_shift +: 8] <= ee_rdata;
      end
      case (cur_addr)
        `SSL_EE_MAXLAT: cfg.max_latency <= ee_rdata;
        `SSL_EE_MINGNT: cfg.min_grant <= ee_rdata;
        `SSL_EE_MAXREC: cfg.max_rec <= ee_rdata[3:0];
        `SSL_EE_LAT: begin
          if (card_mode) begin
            cfg.latency_timer <= {ee_rdata[`SSL_LAT_MSB:`SSL_LAT_LSB], 3'h0};
          end
        end
        `SSL_EE_PHY: begin
          cfg.phy_program_bit <= ee_rdata[1];
          cfg.phy_enhance_bit <= ee_rdata[0];
        end
        default: ;
      endcase
    end
  end

  // card words land in the ssl_cis_mem card word memory, read via cis_rd_addr
  ssl_cis_mem u_cis_mem (
    .sys_clk(sys_clk),
    .wr_be(cis_be),
    .wr_addr(cis_off[6:2]),
    .wr_data({4{ee_rdata}}),
    .rd_addr(cis_rd_addr),
    .rd_data(cis_rd_data)
  );
endmodule

// ---- ssl_param_loader_asserts.sv ----
`timescale 1ns/1ps
`include "ssl_consts.svh"
module ssl_param_loader_asserts import ssl_pkg::*; (
  input wire logic sys_clk,
  input wire logic arst_n,
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic loader_enable_strap,
  input wire logic card_mode_strap,
  input wire logic card_info_enable_strap,
  input wire ssl_ee_req_t ee_req,
  input wire logic ee_ack,
  input wire logic busy
);
  logic started;
  logic [2:0] mode;
  logic [7:0] prev_addr;
  logic prev_ok;
  logic [3:0] wr_cnt;
  logic [11:0] ar_q;
  wire logic ack_hit;
  assign ack_hit = ee_req.req && ee_ack;
  // ----------------------------------------
  // straps as sampled, last byte, write count
  // ----------------------------------------
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      started <= 1'b0;
      mode <= 3'h0;
      prev_addr <= 8'h00;
      prev_ok <= 1'b0;
      wr_cnt <= 4'h0;
      ar_q <= 12'h000;
    end else begin
      started <= 1'b1;
      if (!started) mode <= {loader_enable_strap, card_mode_strap, card_info_enable_strap};
      if (ack_hit) prev_addr <= ee_req.addr;
      prev_ok <= ack_hit ? 1'b1 : (busy ? prev_ok : 1'b0);
      wr_cnt <= !busy ? 4'h0 : wr_cnt + {3'h0, ack_hit && ee_req.write};
      if (s_axi_arvalid && s_axi_arready) ar_q <= s_axi_araddr;
    end
  end
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!arst_n);
  req_hold_a: assert property (ee_req.req && !ee_ack |=> ee_req.req && $stable(ee_req))
    else $error("eeprom request changed before ack");
  req_gap_a: assert property (ack_hit |=> !ee_req.req)
    else $error("eeprom request not dropped after ack");
  byte_ascend_a: assert property ($rose(ee_req.req) && prev_ok
    |-> ee_req.addr == prev_addr + 8'h01)
    else $error("eeprom bytes not in ascending order");
  skip_card_a: assert property (started && mode == 3'b101 && ee_req.req
    && !ee_req.write |-> ee_req.addr <= 8'h23)
    else $error("card words read in pci mode with card info on");
  no_load_a: assert property (started && !mode[2] && ee_req.req |-> ee_req.write)
    else $error("eeprom read with loader disabled");
  eight_bytes_a: assert property ($fell(busy) && wr_cnt != 4'h0 |-> wr_cnt == 4'h8)
    else $error("page write did not store eight bytes");
  idle_quiet_a: assert property (!busy |-> !ee_req.req)
    else $error("eeprom request while not busy");
  page_zero_a: assert property (s_axi_rvalid && ar_q == `SSL_A_PAGE_WR
    |-> s_axi_rdata == 32'h0)
    else $error("page write register read nonzero");
  cov_write: cover property (ack_hit && ee_req.write);
  cov_page: cover property ($fell(busy) && wr_cnt == 4'h8);
  cov_full: cover property (ack_hit && ee_req.addr == 8'hA7);
endmodule
bind ssl_param_loader ssl_param_loader_asserts ssl_param_loader_asserts_inst (.sys_clk, .arst_n,
  .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid,
  .loader_enable_strap, .card_mode_strap, .card_info_enable_strap, .ee_req, .ee_ack, .busy);

// ---- ssl_param_loader_tb.sv ----
`timescale 1ns/1ps
`include "ssl_consts.svh"
`define TB_CHK(nm, e, g) begin compares++; if ((g) !== (e)) begin failures++; \
  $display("[FAIL] %s exp %0h got %0h", nm, e, g); end end
module ssl_param_loader_tb import ssl_pkg::*;;
  logic sys_clk = 1'b0, arst_n = 1'b0, slow = 1'b0;
  logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_arvalid = 1'b0;
  logic s_axi_bready = 1'b1, s_axi_rready = 1'b1;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic loader_enable_strap = 1'b0, card_mode_strap = 1'b0, card_info_enable_strap = 1'b0;
  logic [4:0] cis_rd_addr = 5'h00;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, ee_ack, busy;
  logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
  logic [31:0] s_axi_rdata, cis_rd_data, rdv;
  logic [7:0] ee_rdata, rd_max, wr_first;
  ssl_ee_req_t ee_req;
  ssl_cfg_t cfg;
  int failures = 0, compares = 0, rd_n = 0, wr_n = 0;
  ssl_param_loader ssl_param_loader_inst (.sys_clk, .arst_n, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .loader_enable_strap, .card_mode_strap,
    .card_info_enable_strap, .ee_req, .ee_ack, .ee_rdata, .cfg, .cis_rd_addr, .cis_rd_data, .busy);
  ssl_ee_model ssl_ee_model_inst (.sys_clk, .slow, .ee_req, .ee_ack, .ee_rdata);
  always #5 sys_clk = ~sys_clk;
  always @(posedge sys_clk) begin
    if (ee_req.req && ee_ack && ee_req.write) begin
      if (wr_n == 0) wr_first <= ee_req.addr;
      wr_n <= wr_n + 1;
    end else if (ee_req.req && ee_ack) begin
      if (ee_req.addr > rd_max) rd_max <= ee_req.addr;
      rd_n <= rd_n + 1;
    end
  end
  // ----------------------------------------
  // bus and sequencing helpers
  // ----------------------------------------
  task end_of_test;
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task tmo(input int n);
    if (n >= 6000) begin
      failures++;
      $display("[FAIL] wait exp done got stuck");
      end_of_test();
    end
  endtask
  task automatic axi_wr(input logic [11:0] a, input logic [31:0] d);
    int n = 0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    do begin
      @(posedge sys_clk);
      n++;
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1 && n < 6000);
    tmo(n);
    rsp = s_axi_bresp;
  endtask
  task automatic axi_rd(input logic [11:0] a);
    int n = 0;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do begin
      @(posedge sys_clk);
      n++;
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1 && n < 6000);
    tmo(n);
    rdv = s_axi_rdata;
    rsp = s_axi_rresp;
  endtask
  task automatic wait_idle;
    int n = 0;
    do begin
      @(posedge sys_clk);
      n++;
    end while (busy !== 1'b0 && n < 6000);
    tmo(n);
  endtask
  task do_reset(input logic le, cm, ci, sl);
    arst_n <= 1'b0;
    loader_enable_strap <= le;
    card_mode_strap <= cm;
    card_info_enable_strap <= ci;
    slow <= sl;
    rd_max <= 8'h00;
    rd_n <= 0;
    repeat (2) @(posedge sys_clk);
    arst_n <= 1'b1;
    @(posedge sys_clk);
  endtask
  task cis_word(input logic [4:0] i);
    cis_rd_addr <= i;
    repeat (2) @(posedge sys_clk);
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task t_load_full;
    do_reset(1'b1, 1'b1, 1'b0, 1'b1);
    `TB_CHK("busy", 1'h1, busy)
    wait_idle();
    `TB_CHK("subsys", 32'h40414243, cfg.subsys_ids)
    `TB_CHK("maxlat", 8'h44, cfg.max_latency)
    `TB_CHK("mingnt", 8'h45, cfg.min_grant)
    `TB_CHK("maxrec", 4'h7, cfg.max_rec)
    `TB_CHK("guid", 64'h48494A4B4C4D4E4F, {cfg.guid_hi, cfg.guid_lo})
    `TB_CHK("lat", 8'h50, cfg.latency_timer)
    `TB_CHK("gen", 96'h5C5D5E5F_58595A5B_54555657, cfg.general)
    `TB_CHK("phy", 2'h1, {cfg.phy_program_bit, cfg.phy_enhance_bit})
    `TB_CHK("reads", 168, rd_n)
    `TB_CHK("last", 8'hA7, rd_max)
    axi_rd(`SSL_A_STATUS);
    `TB_CHK("status", 32'h0000_0002, rdv)
    cis_word(5'h00);
    `TB_CHK("card0", 32'h68696A6B, cis_rd_data)
    cis_word(5'h1F);
    `TB_CHK("card31", 32'hE4E5E6E7, cis_rd_data)
    $display("test load_full done");
  endtask
  task t_load_modes;
    do_reset(1'b1, 1'b0, 1'b1, 1'b0);
    wait_idle();
    `TB_CHK("last", 8'h23, rd_max)
    `TB_CHK("lat", 8'h00, cfg.latency_timer)
    do_reset(1'b1, 1'b0, 1'b0, 1'b0);
    wait_idle();
    `TB_CHK("last", 8'hA7, rd_max)
    do_reset(1'b0, 1'b1, 1'b0, 1'b0);
    repeat (3) @(posedge sys_clk);
    `TB_CHK("busy", 1'b0, busy)
    `TB_CHK("reads", 0, rd_n)
    `TB_CHK("subsys", 32'h0, cfg.subsys_ids)
    $display("test load_modes done");
  endtask
  task t_regs;
    axi_wr(`SSL_A_CIS_EVEN, 32'h11223344);
    axi_wr(`SSL_A_CIS_ODD, 32'h55667788);
    axi_rd(`SSL_A_CIS_EVEN);
    `TB_CHK("even", 32'h11223344, rdv)
    axi_rd(`SSL_A_CIS_ODD);
    `TB_CHK("odd", 32'h55667788, rdv)
    axi_wr(`SSL_A_PAGE_WR, 32'h50);
    repeat (2) @(posedge sys_clk);
    `TB_CHK("busy", 1'b0, busy)
    axi_rd(`SSL_A_PAGE_WR);
    `TB_CHK("page", 32'h0, rdv)
    axi_rd(12'h9F0);
    `TB_CHK("rresp", `SSL_RESP_SLVERR, rsp)
    axi_wr(12'h9F0, 32'h1);
    `TB_CHK("bresp", `SSL_RESP_SLVERR, rsp)
    $display("test regs done");
  endtask
  task t_pages;
    axi_wr(`SSL_A_SUBSYS, 32'hA1B2C3D4);
    axi_wr(`SSL_A_LATENCY_VALUES_STAGE, 32'hE1F2_0009);
    axi_wr(`SSL_A_GUID_HI, 32'h0123_4567);
    axi_wr(`SSL_A_GUID_LO, 32'h89AB_CDEF);
    axi_wr(`SSL_A_LAT, 32'h0000_00A8);
    axi_wr(`SSL_A_GEN0, 32'hC0C1_C2C3);
    axi_wr(`SSL_A_GEN1, 32'hD0D1_D2D3);
    axi_wr(`SSL_A_GEN2, 32'hE0E1_E2E3);
    for (int p = 0; p < 6; p++) begin
      wr_n <= 0;
      axi_wr(`SSL_A_PAGE_WR, {25'h0, 3'(p), 4'h1});
      `TB_CHK("busy", 1'b1, busy)
      if (p == 0) axi_wr(`SSL_A_PAGE_WR, 32'h51);
      wait_idle();
      repeat (4) @(posedge sys_clk);
      `TB_CHK("count", 8, wr_n)
      `TB_CHK("base", 8'(p * 8), wr_first)
    end
    `TB_CHK("ids", 32'hA1B2C3D4, {ssl_ee_model_inst.mem[0], ssl_ee_model_inst.mem[1],
      ssl_ee_model_inst.mem[2], ssl_ee_model_inst.mem[3]})
    `TB_CHK("const", 8'h08, ssl_ee_model_inst.mem[6])
    `TB_CHK("pair", 32'h55667788, {ssl_ee_model_inst.mem[8'h2C], ssl_ee_model_inst.mem[8'h2D],
      ssl_ee_model_inst.mem[8'h2E], ssl_ee_model_inst.mem[8'h2F]})
    axi_wr(`SSL_A_CIS_EVEN, 32'h99AABBCC);
    wr_n <= 0;
    axi_wr(`SSL_A_PAGE_WR, 32'h51);
    wait_idle();
    `TB_CHK("next", 8'h30, wr_first)
    `TB_CHK("noload", 32'h0, cfg.subsys_ids)
    do_reset(1'b1, 1'b1, 1'b0, 1'b0);
    wait_idle();
    `TB_CHK("reload", 32'hA1B2C3D4, cfg.subsys_ids)
    `TB_CHK("latency_values_stage", 20'hE1F29, {cfg.max_latency, cfg.min_grant, cfg.max_rec})
    `TB_CHK("guid", 64'h0123456789ABCDEF, {cfg.guid_hi, cfg.guid_lo})
    `TB_CHK("lat", 8'hA8, cfg.latency_timer)
    `TB_CHK("gen", 96'hE0E1E2E3_D0D1D2D3_C0C1C2C3, cfg.general)
    `TB_CHK("phy", 2'h2, {cfg.phy_program_bit, cfg.phy_enhance_bit})
    cis_word(5'h02);
    `TB_CHK("card2", 32'h99AABBCC, cis_rd_data)
    cis_word(5'h03);
    `TB_CHK("card3", 32'h55667788, cis_rd_data)
    $display("test pages done");
  endtask
  initial begin
    t_load_full();
    t_load_modes();
    t_regs();
    t_pages();
    end_of_test();
  end
endmodule

// ---- ssl_pkg.sv ----
package ssl_pkg;

  typedef enum logic [1:0] {
    SSL_IDLE = 2'h0,
    SSL_REQ  = 2'h1,
    SSL_WAIT = 2'h3
  } ssl_state_t;

  typedef struct packed {
    logic req;
    logic write;
    logic [7:0] addr;
    logic [7:0] wdata;
  } ssl_ee_req_t;

  typedef struct packed {
    logic [31:0] subsys_ids;
    logic [7:0] max_latency;
    logic [7:0] min_grant;
    logic [3:0] max_rec;
    logic [31:0] guid_hi;
    logic [31:0] guid_lo;
    logic [7:0] latency_timer;
    logic [2:0][31:0] general;
    logic phy_program_bit;
    logic phy_enhance_bit;
  } ssl_cfg_t;

endpackage
